// ==== core/slm_mode_ctl.v ====
`timescale 1ns/10ps
`default_nettype none
`include "slm_consts.vh"

module slm_mode_ctl (
  input wire clk_sys_i,
  input wire rst_n_i,
  input wire [7:0] reg_addr_i,
  input wire reg_wr_i,
  input wire [7:0] reg_wdata_i,
  input wire reg_rd_i,
  output reg [7:0] reg_rdata_o,
  output reg reg_rvalid_o,
  input wire rx0_present_i,
  input wire rx0_dual_cap_i,
  input wire rx0_high_speed_control_channel_cap_i,
  input wire rx1_present_i,
  input wire [7:0] pixel_freq_mhz_i,
  input wire [23:0] pix_data_i,
  input wire pix_valid_i,
  output reg [4:0] link_mode_o,
  output reg tx0_en_o,
  output reg tx1_en_o,
  output reg tx1_back_en_o,
  output reg high_speed_control_channel_o,
  output reg half_rate_o,
  output reg legacy_ok_o,
  output reg freq_over_o,
  output reg pll_reset_o,
  output reg coax_mode_o,
  output reg [23:0] tx0_data_o,
  output reg tx0_valid_o,
  output reg [23:0] tx1_data_o,
  output reg tx1_valid_o
);

// -----------------------------------------
// register file
// -----------------------------------------
reg [7:0] link_port_selector;
reg [7:0] cap_port0;
reg [7:0] cap_port1;
reg [7:0] dual_link_control;
reg [4:0] mode;
reg pix_phase;

wire [2:0] ctl_mode;
wire sel_port1;
wire pll_reset_on_freq_change;
wire auto_on;
wire freq_change;

assign ctl_mode = dual_link_control[`SLM_CTL_MODE_HI:`SLM_CTL_MODE_LO];
assign sel_port1 = (link_port_selector == `SLM_SEL_PORT1);
assign pll_reset_on_freq_change = dual_link_control[`SLM_CTL_PLL_RST];
assign auto_on = (ctl_mode == `SLM_MODE_AUTO) ||
  (ctl_mode == `SLM_MODE_AUTO_NO_DUAL);

always @(posedge clk_sys_i or negedge rst_n_i) begin
  if (!rst_n_i) begin
    link_port_selector <= `SLM_RST_PORT_SEL;
    cap_port0 <= `SLM_RST_CAP;
    cap_port1 <= `SLM_RST_CAP;
    dual_link_control <= `SLM_RST_CTL;
  end else if (reg_wr_i) begin
    case (reg_addr_i)
      `SLM_OFS_PORT_SEL: begin
        link_port_selector <= reg_wdata_i;
      end
      `SLM_OFS_CAP: begin
        // capability write lands on the selected port
        if (sel_port1) begin
          cap_port1 <= reg_wdata_i;
        end else begin
          cap_port0 <= reg_wdata_i;
        end
      end
      `SLM_OFS_CTL: begin
        dual_link_control <= reg_wdata_i;
      end
      default: begin
        link_port_selector <= link_port_selector;
      end
    endcase
  end
end

// -----------------------------------------
// register read, one cycle after strobe
// -----------------------------------------
reg [7:0] next_rdata;

always @* begin
  case (reg_addr_i)
    `SLM_OFS_PORT_SEL: next_rdata = link_port_selector;
    `SLM_OFS_CAP: next_rdata = sel_port1 ? cap_port1 : cap_port0;
    `SLM_OFS_CTL: next_rdata = dual_link_control;
    `SLM_OFS_STATUS: next_rdata = {3'h0, mode};
    default: next_rdata = 8'h00;
  endcase
end

always @(posedge clk_sys_i or negedge rst_n_i) begin
  if (!rst_n_i) begin
    reg_rdata_o <= 8'h00;
    reg_rvalid_o <= 1'b0;
  end else begin
    reg_rvalid_o <= reg_rd_i;
    if (reg_rd_i) begin
      reg_rdata_o <= next_rdata;
    end
  end
end

// -----------------------------------------
// capability resolve
// -----------------------------------------
wire rx0_dual;
wire rx1_high_speed_control_channel;
wire above_min;

// forced capability is ORed with what the link reports
assign rx0_dual = rx0_dual_cap_i ||
  (cap_port0[`SLM_CAP_FORCE] && cap_port0[`SLM_CAP_DUAL]);
assign rx1_high_speed_control_channel = rx0_high_speed_control_channel_cap_i ||
  (cap_port1[`SLM_CAP_FORCE] && cap_port1[`SLM_CAP_DUAL]);
assign above_min = (pixel_freq_mhz_i > `SLM_FREQ_DUAL_MIN);

// -----------------------------------------
// mode selection
// -----------------------------------------
reg [4:0] next_mode;

always @* begin
  next_mode = `SLM_ST_IDLE;
  case (ctl_mode)
    `SLM_MODE_FORCE_DUAL: begin
      next_mode = `SLM_ST_DUAL;
    end
    `SLM_MODE_FORCE_SINGLE: begin
      next_mode = `SLM_ST_SINGLE;
    end
    `SLM_MODE_AUTO, `SLM_MODE_AUTO_NO_DUAL: begin
      if (rx0_present_i && rx0_dual && above_min &&
          ctl_mode == `SLM_MODE_AUTO) begin
        next_mode = `SLM_ST_DUAL;
      end else if (rx0_present_i && rx1_present_i && !rx0_dual) begin
        next_mode = `SLM_ST_REPL;
      end else if (rx0_present_i) begin
        next_mode = `SLM_ST_SINGLE;
      end else if (rx1_present_i) begin
        next_mode = `SLM_ST_SEC;
      end else begin
        next_mode = `SLM_ST_IDLE;
      end
    end
    default: begin
      next_mode = `SLM_ST_SINGLE;
    end
  endcase
end

always @(posedge clk_sys_i or negedge rst_n_i) begin
  if (!rst_n_i) begin
    mode <= `SLM_ST_IDLE;
  end else begin
    mode <= next_mode;
  end
end

// -----------------------------------------
// link enables and status
// -----------------------------------------
reg next_tx0;
reg next_tx1;
reg next_back;
reg next_high_speed_control_channel;
reg next_over;

always @* begin
  next_tx0 = 1'b0;
  next_tx1 = 1'b0;
  next_back = 1'b0;
  next_high_speed_control_channel = 1'b0;
  next_over = 1'b0;
  case (mode)
    `SLM_ST_SINGLE: begin
      next_tx0 = 1'b1;
      next_over = (pixel_freq_mhz_i > `SLM_FREQ_SINGLE_MAX);
      if (ctl_mode != `SLM_MODE_FORCE_SINGLE) begin
        next_high_speed_control_channel = rx1_high_speed_control_channel;
        next_tx1 = rx1_high_speed_control_channel;
        next_back = rx1_high_speed_control_channel;
      end
    end
    `SLM_ST_DUAL: begin
      next_tx0 = 1'b1;
      next_tx1 = 1'b1;
      next_back = 1'b1;
      next_high_speed_control_channel = rx1_high_speed_control_channel;
      next_over = (pixel_freq_mhz_i > `SLM_FREQ_DUAL_MAX);
    end
    `SLM_ST_REPL: begin
      next_tx0 = 1'b1;
      next_tx1 = 1'b1;
      next_back = 1'b1;
      next_over = (pixel_freq_mhz_i > `SLM_FREQ_REPL_MAX);
    end
    `SLM_ST_SEC: begin
      next_tx1 = 1'b1;
      next_back = 1'b1;
      next_over = (pixel_freq_mhz_i > `SLM_FREQ_SINGLE_MAX);
    end
    `SLM_ST_IDLE: begin
      next_tx0 = 1'b0;
    end
    default: begin
      next_tx0 = 1'b0;
    end
  endcase
end

always @(posedge clk_sys_i or negedge rst_n_i) begin
  if (!rst_n_i) begin
    link_mode_o <= `SLM_ST_IDLE;
    tx0_en_o <= 1'b0;
    tx1_en_o <= 1'b0;
    tx1_back_en_o <= 1'b0;
    high_speed_control_channel_o <= 1'b0;
    half_rate_o <= 1'b0;
    legacy_ok_o <= 1'b0;
    freq_over_o <= 1'b0;
    coax_mode_o <= 1'b0;
  end else begin
    link_mode_o <= mode;
    tx0_en_o <= next_tx0;
    tx1_en_o <= next_tx1;
    tx1_back_en_o <= next_back;
    high_speed_control_channel_o <= next_high_speed_control_channel;
    half_rate_o <= (mode == `SLM_ST_DUAL);
    legacy_ok_o <= (mode == `SLM_ST_SINGLE) &&
      (pixel_freq_mhz_i < `SLM_FREQ_LEGACY_MAX);
    freq_over_o <= next_over;
    coax_mode_o <= dual_link_control[`SLM_CTL_COAX];
  end
end

// -----------------------------------------
// pll reset on frequency change
// -----------------------------------------
slm_freq_watch u_freq_watch (
  .clk_sys_i(clk_sys_i),
  .rst_n_i(rst_n_i),
  .freq_i(pixel_freq_mhz_i),
  .enable_i(pll_reset_on_freq_change),
  .change_o(freq_change)
);

always @(posedge clk_sys_i or negedge rst_n_i) begin
  if (!rst_n_i) begin
    pll_reset_o <= 1'b0;
  end else begin
    pll_reset_o <= freq_change;
  end
end

// -----------------------------------------
// pixel steering
// -----------------------------------------
always @(posedge clk_sys_i or negedge rst_n_i) begin
  if (!rst_n_i) begin
    pix_phase <= 1'b0;
    tx0_data_o <= 24'h000000;
    tx0_valid_o <= 1'b0;
    tx1_data_o <= 24'h000000;
    tx1_valid_o <= 1'b0;
  end else begin
    tx0_valid_o <= 1'b0;
    tx1_valid_o <= 1'b0;
    if (mode != `SLM_ST_DUAL) begin
      pix_phase <= 1'b0;
    end
    if (pix_valid_i) begin
      case (mode)
        `SLM_ST_SINGLE: begin
          tx0_data_o <= pix_data_i;
          tx0_valid_o <= 1'b1;
        end
        `SLM_ST_DUAL: begin
          // even pixels on link 0, odd on link 1
          pix_phase <= ~pix_phase;
          if (pix_phase) begin
            tx1_data_o <= pix_data_i;
            tx1_valid_o <= 1'b1;
          end else begin
            tx0_data_o <= pix_data_i;
            tx0_valid_o <= 1'b1;
          end
        end
        `SLM_ST_REPL: begin
          tx0_data_o <= pix_data_i;
          tx0_valid_o <= 1'b1;
          tx1_data_o <= pix_data_i;
          tx1_valid_o <= 1'b1;
        end
        `SLM_ST_SEC: begin
          tx1_data_o <= pix_data_i;
          tx1_valid_o <= 1'b1;
        end
        default: begin
          tx0_valid_o <= 1'b0;
        end
      endcase
    end
  end
end

endmodule
`default_nettype wire

// ==== inc/slm_consts.vh ====
// What this block does
// - single mode sends the whole stream on link 0, up to 96 MHz.
// - single mode flags older-receiver compatibility only below 85 MHz.
// - forced single mode turns off secondary transmit phy and back channel.
// - dual mode sends alternate pixels on the two links.
// - dual mode accepts up to 210 MHz, each port at half rate.
// - auto mode picks dual for dual-capable receiver above minimum frequency.
// - dual mode, or single mode other than forced single, lets link 1 carry control traffic if supported.
// - control bits 2:0 = 011b disable auto-detect and force dual mode.
// - control bits 2:0 = 100b keep auto-detect but forbid dual mode.
// - replicate mode sends identical video to both links, up to 105 MHz.
// - auto mode picks replicate when two independent receivers are found.
// - receiver only on link 1 lets video go on link 1 alone.
// - auto mode decides from receiver capabilities and measured pixel frequency.
// - control register can turn auto-detection off for a forced mode.
// - control bit 5 enables PLL reset on frequency change; software clears it.
`ifndef SLM_CONSTS_VH
`define SLM_CONSTS_VH

// register offsets
`define SLM_OFS_PORT_SEL 8'h1e
`define SLM_OFS_CAP 8'h20
`define SLM_OFS_CTL 8'h5b
`define SLM_OFS_STATUS 8'h5c

// reset values
`define SLM_RST_PORT_SEL 8'h01
`define SLM_RST_CAP 8'h00
`define SLM_RST_CTL 8'h20

// port selector codes
`define SLM_SEL_PORT0 8'h01
`define SLM_SEL_PORT1 8'h02

// capability fields
`define SLM_CAP_FORCE 7
`define SLM_CAP_DUAL 0
`define SLM_CAP_HIGH_SPEED_CONTROL_CHANNEL 1

// control fields
`define SLM_CTL_COAX 7
`define SLM_CTL_PLL_RST 5
`define SLM_CTL_MODE_HI 2
`define SLM_CTL_MODE_LO 0
`define SLM_MODE_AUTO 3'h0
`define SLM_MODE_FORCE_SINGLE 3'h1
`define SLM_MODE_FORCE_DUAL 3'h3
`define SLM_MODE_AUTO_NO_DUAL 3'h4

// frequency limits in MHz
`define SLM_FREQ_SINGLE_MAX 8'h60
`define SLM_FREQ_LEGACY_MAX 8'h55
`define SLM_FREQ_DUAL_MAX 8'hd2
`define SLM_FREQ_REPL_MAX 8'h69
`define SLM_FREQ_DUAL_MIN 8'h41
`define SLM_FREQ_TOL 8'h02

// one-hot link modes
`define SLM_ST_IDLE 5'h01
`define SLM_ST_SINGLE 5'h02
`define SLM_ST_DUAL 5'h04
`define SLM_ST_REPL 5'h08
`define SLM_ST_SEC 5'h10

`endif

// ==== core/slm_freq_watch.v ====
`timescale 1ns/10ps
`default_nettype none
`include "slm_consts.vh"

module slm_freq_watch (
  input wire clk_sys_i,
  input wire rst_n_i,
  input wire [7:0] freq_i,
  input wire enable_i,
  output reg change_o
);

reg [7:0] last_freq;
wire [7:0] diff;

assign diff = (freq_i > last_freq) ? (freq_i - last_freq) :
  (last_freq - freq_i);

// -----------------------------------------
// change beyond tolerance, one-cycle pulse
// -----------------------------------------
always @(posedge clk_sys_i or negedge rst_n_i) begin
  if (!rst_n_i) begin
    last_freq <= 8'h00;
    change_o <= 1'b0;
  end else begin
    change_o <= 1'b0;
    if (diff > `SLM_FREQ_TOL) begin
      last_freq <= freq_i;
      change_o <= enable_i;
    end
  end
end

endmodule
`default_nettype wire

// ==== tb/slm_mode_ctl_chk.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "slm_consts.vh"
module slm_mode_ctl_chk (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic reg_rd_i,
  input wire logic reg_rvalid_o,
  input wire logic pix_valid_i,
  input wire logic [23:0] pix_data_i,
  input wire logic [7:0] pixel_freq_mhz_i,
  input wire logic [4:0] link_mode_o,
  input wire logic tx0_valid_o,
  input wire logic [23:0] tx0_data_o,
  input wire logic tx1_valid_o,
  input wire logic [23:0] tx1_data_o,
  input wire logic half_rate_o,
  input wire logic legacy_ok_o,
  input wire logic freq_over_o,
  input wire logic pll_reset_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  rd_answer_a: assert property (reg_rd_i |=> reg_rvalid_o)
    else $error("read answer missing");
  single_steer_a: assert property (
    (pix_valid_i && link_mode_o == `SLM_ST_SINGLE) ##1
    link_mode_o == `SLM_ST_SINGLE |-> tx0_valid_o && !tx1_valid_o &&
    tx0_data_o == $past(pix_data_i)) else $error("single steer wrong");
  dual_split_a: assert property (
    link_mode_o == `SLM_ST_DUAL |-> !(tx0_valid_o && tx1_valid_o))
    else $error("dual pixel sent twice");
  half_rate_a: assert property (
    half_rate_o == (link_mode_o == `SLM_ST_DUAL))
    else $error("half rate wrong");
  repl_both_a: assert property (
    (pix_valid_i && link_mode_o == `SLM_ST_REPL) ##1
    link_mode_o == `SLM_ST_REPL |-> tx0_valid_o && tx1_valid_o &&
    tx1_data_o == tx0_data_o) else $error("replicate wrong");
  sec_only_a: assert property (
    (pix_valid_i && link_mode_o == `SLM_ST_SEC) ##1
    link_mode_o == `SLM_ST_SEC |-> tx1_valid_o && !tx0_valid_o)
    else $error("secondary steer wrong");
  legacy_lim_a: assert property (
    $stable(pixel_freq_mhz_i)[*4] ##0 legacy_ok_o |->
    pixel_freq_mhz_i < `SLM_FREQ_LEGACY_MAX) else $error("legacy flag wrong");
  dual_over_a: assert property (
    (link_mode_o == `SLM_ST_DUAL &&
    pixel_freq_mhz_i > `SLM_FREQ_DUAL_MAX)[*4] |-> freq_over_o)
    else $error("dual over flag missing");
  pll_pulse_a: assert property (pll_reset_o |=> !pll_reset_o)
    else $error("pll pulse too long");
endmodule
bind slm_mode_ctl slm_mode_ctl_chk chk_u (.clk_sys_i(clk_sys_i),
  .rst_n_i(rst_n_i), .reg_rd_i(reg_rd_i), .reg_rvalid_o(reg_rvalid_o),
  .pix_valid_i(pix_valid_i), .pix_data_i(pix_data_i),
  .pixel_freq_mhz_i(pixel_freq_mhz_i), .link_mode_o(link_mode_o),
  .tx0_valid_o(tx0_valid_o), .tx0_data_o(tx0_data_o),
  .tx1_valid_o(tx1_valid_o), .tx1_data_o(tx1_data_o),
  .half_rate_o(half_rate_o), .legacy_ok_o(legacy_ok_o),
  .freq_over_o(freq_over_o), .pll_reset_o(pll_reset_o));
`default_nettype wire

// ==== tb/slm_rx_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module slm_rx_model (
  input wire logic clk_sys_i,
  input wire logic [3:0] cfg_i,
  output logic rx0_present_o,
  output logic rx0_dual_cap_o,
  output logic rx0_high_speed_control_channel_cap_o,
  output logic rx1_present_o,
  input wire logic tx0_valid_i,
  input wire logic [23:0] tx0_data_i,
  input wire logic tx1_valid_i,
  input wire logic [23:0] tx1_data_i
);
  logic [23:0] q0[$];
  logic [23:0] q1[$];
  assign {rx0_present_o, rx0_dual_cap_o, rx0_high_speed_control_channel_cap_o, rx1_present_o} =
    cfg_i;
  always @(posedge clk_sys_i) begin
    if (tx0_valid_i === 1'b1) q0.push_back(tx0_data_i);
    if (tx1_valid_i === 1'b1) q1.push_back(tx1_data_i);
  end
endmodule
`default_nettype wire

// ==== tb/serial_link_mode_control_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "slm_consts.vh"
module serial_link_mode_control_tb;
  logic clk_sys_i = 0, rst_n_i = 0, reg_wr_i = 0, reg_rd_i = 0;
  logic [7:0] reg_addr_i = 0, reg_wdata_i = 0, freq = 8'h32;
  logic [23:0] pix_data_i = 0;
  logic pix_valid_i = 0;
  logic [3:0] cfg = 0;
  wire r0p, r0d, r0h, r1p, t0v, t1v, t1e, t1b, hs, hr, lg, fo, pr;
  wire t0e, co;
  wire [23:0] t0d, t1d;
  wire [7:0] rdat;
  wire rv;
  wire [4:0] mode;
  int errors = 0, checked = 0;
  logic [23:0] e0[$];
  logic [23:0] e1[$];
  logic [27:0] tbl[9] = '{28'h0110042, 28'h0110041, 28'h010016a,
    28'h0000132, 28'h0000032, 28'h4110096, 28'h30000d3, 28'h1101146,
    28'h5100050};
  always #25 clk_sys_i = ~clk_sys_i;
  slm_rx_model rx_u (.clk_sys_i(clk_sys_i), .cfg_i(cfg),
    .rx0_present_o(r0p), .rx0_dual_cap_o(r0d), .rx0_high_speed_control_channel_cap_o(r0h),
    .rx1_present_o(r1p), .tx0_valid_i(t0v), .tx0_data_i(t0d),
    .tx1_valid_i(t1v), .tx1_data_i(t1d));
  slm_mode_ctl dut_u (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(rdat), .reg_rvalid_o(rv),
    .rx0_present_i(r0p), .rx0_dual_cap_i(r0d), .rx0_high_speed_control_channel_cap_i(r0h),
    .rx1_present_i(r1p), .pixel_freq_mhz_i(freq), .pix_data_i(pix_data_i),
    .pix_valid_i(pix_valid_i), .link_mode_o(mode), .tx0_en_o(t0e),
    .tx1_en_o(t1e), .tx1_back_en_o(t1b), .high_speed_control_channel_o(hs),
    .half_rate_o(hr), .legacy_ok_o(lg), .freq_over_o(fo),
    .pll_reset_o(pr), .coax_mode_o(co), .tx0_data_o(t0d), .tx0_valid_o(t0v),
    .tx1_data_o(t1d), .tx1_valid_o(t1v));
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task close_out;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge clk_sys_i) {reg_addr_i, reg_wdata_i, reg_wr_i} = {a, v, 1'b1};
    @(negedge clk_sys_i) reg_wr_i = 0;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] v);
    @(negedge clk_sys_i) {reg_addr_i, reg_rd_i} = {a, 1'b1};
    @(negedge clk_sys_i) reg_rd_i = 0;
    chk({rv, rdat}, {1'b1, v});
  endtask
  task pll_watch(input logic [7:0] f, input logic exp);
    logic seen;
    seen = 0;
    @(negedge clk_sys_i) freq = f;
    repeat (5) @(negedge clk_sys_i) seen |= pr;
    chk(seen, exp);
  endtask
  function automatic logic [4:0] exp_mode(int c, p0, d0, p1, f);
    if (c == 3) return `SLM_ST_DUAL;
    if (c != 0 && c != 4) return `SLM_ST_SINGLE;
    if (c == 0 && p0 && d0 && f > `SLM_FREQ_DUAL_MIN) return `SLM_ST_DUAL;
    if (p0 && p1 && !d0) return `SLM_ST_REPL;
    if (p0) return `SLM_ST_SINGLE;
    if (p1) return `SLM_ST_SEC;
    return `SLM_ST_IDLE;
  endfunction
  initial begin
    #1000000;
    errors++;
    close_out;
  end
  initial begin
    logic [4:0] m;
    logic [3:0] en;
    int c, f, lim;
    void'($urandom(32'h3029697d));
    repeat (8) @(negedge clk_sys_i);
    rst_n_i = 1;
    rd(`SLM_OFS_CTL, 8'h20);
    rd(`SLM_OFS_PORT_SEL, 8'h01);
    rd(8'hff, 8'h00);
    pll_watch(8'h3c, 1);
    wr(`SLM_OFS_PORT_SEL, 8'h02);
    wr(`SLM_OFS_CAP, 8'h8f);
    rd(`SLM_OFS_CAP, 8'h8f);
    wr(`SLM_OFS_PORT_SEL, 8'h01);
    rd(`SLM_OFS_CAP, 8'h00);
    wr(`SLM_OFS_CTL, 8'h00);
    pll_watch(8'h46, 0);
    $display("register test done");
    for (int i = 0; i < 9; i++) begin
      c = tbl[i][27:24];
      f = tbl[i][7:0];
      @(negedge clk_sys_i) cfg = {tbl[i][20], tbl[i][16], tbl[i][12], tbl[i][8]};
      freq = f;
      wr(`SLM_OFS_CTL, {i[0], 7'(c)});
      repeat (4) @(negedge clk_sys_i);
      m = exp_mode(c, cfg[3], cfg[2], cfg[0], f);
      lim = m == `SLM_ST_DUAL ? 210 : m == `SLM_ST_REPL ? 105 : 96;
      chk(mode, m);
      chk(hr, m == `SLM_ST_DUAL);
      chk(lg, m == `SLM_ST_SINGLE && f < 85);
      chk(fo, m != `SLM_ST_IDLE && f > lim);
      if (c == 1) chk({t1e, t1b, hs}, 0);
      // port 1 capability was forced, so control traffic is available
      en[3] = m != `SLM_ST_IDLE && m != `SLM_ST_SEC;
      en[2:1] = {2{m != `SLM_ST_IDLE && !(m == `SLM_ST_SINGLE && c == 1)}};
      en[0] = m == `SLM_ST_DUAL || (m == `SLM_ST_SINGLE && c != 1);
      chk({t0e, t1e, t1b, hs}, en);
      chk(co, i[0]);
      rd(`SLM_OFS_STATUS, {3'h0, m});
      for (int k = 0; k < 4; k++) begin
        @(negedge clk_sys_i) {pix_valid_i, pix_data_i} = {1'b1, 24'($urandom)};
        if (m == `SLM_ST_SINGLE || m == `SLM_ST_REPL ||
            (m == `SLM_ST_DUAL && k % 2 == 0)) e0.push_back(pix_data_i);
        if (m == `SLM_ST_SEC || m == `SLM_ST_REPL ||
            (m == `SLM_ST_DUAL && k % 2 == 1)) e1.push_back(pix_data_i);
      end
      @(negedge clk_sys_i) pix_valid_i = 0;
      repeat (2) @(negedge clk_sys_i);
      chk(rx_u.q0.size(), e0.size());
      chk(rx_u.q1.size(), e1.size());
      foreach (e0[k]) chk(rx_u.q0[k], e0[k]);
      foreach (e1[k]) chk(rx_u.q1[k], e1[k]);
      rx_u.q0.delete();
      rx_u.q1.delete();
      e0.delete();
      e1.delete();
      $display("test %0d done", i);
    end
    close_out;
  end
endmodule
`default_nettype wire
